// ---- common/tal_cfg.svh ----
`ifndef TAL_CFG_SVH
`define TAL_CFG_SVH
// System clock and link bit clock rates in Hz
`define TAL_CLK_HZ 10000000
`define TAL_BCLK_HZ 12288000
// Master bit clock half period, rounded down, never below one cycle
`define TAL_BCLK_HALF_CYC (((`TAL_CLK_HZ / (2 * `TAL_BCLK_HZ)) > 0) ? \
    (`TAL_CLK_HZ / (2 * `TAL_BCLK_HZ)) : 1)
// Frame layout
`define TAL_FRAME_BITS 256
`define TAL_TAG_TOP 5'h0F
`define TAL_SLOT_TOP 5'h13
`define TAL_LAST_SLOT 4'hC
`define TAL_SYNC_BITS 8'h10
// Register indices answered by the device
`define TAL_IDX_VID1 7'h7C
`define TAL_IDX_VID2 7'h7E
// Playback slot numbers per route
`define TAL_SLOT_FRONT_L 4'h3
`define TAL_SLOT_FRONT_R 4'h4
`define TAL_SLOT_SURR_L 4'h7
`define TAL_SLOT_SURR_R 4'h8
`define TAL_SLOT_CLFE_L 4'h6
`define TAL_SLOT_CLFE_R 4'h9
// Controller register offsets
`define TAL_REG_CTRL 8'h00
`define TAL_REG_LEFT 8'h04
`define TAL_REG_RIGHT 8'h08
`define TAL_REG_MASK 8'h0C
`define TAL_REG_CMD 8'h10
`define TAL_REG_STAT 8'h14
// Control bit positions and reset value
`define TAL_CTRL_RUN 0
`define TAL_CTRL_ATE 1
`define TAL_CTRL_VEND 2
`define TAL_CTRL_MONO 3
`define TAL_CTRL_RST 4'h0
// Receive positions seen by the controller
`define TAL_RX_S2_END 8'h37
`endif

// ---- common/tal_link_if.sv ----
`timescale 1ns/1ps
interface tal_link_if;
    logic link_reset_n;     // Link reset, low active
    logic sync;             // Frame sync from controller
    logic sdata_out;        // Controller to device serial data
    logic bit_clk_dev;      // Bit clock driven by a master device
    logic bit_clk_dev_oe_n; // Low while the device drives the bit clock
    logic bit_clk_ext;      // Bit clock from another link master
    logic sdata_in_dev;     // Device to controller serial data
    logic sdata_in_oe_n;    // Low while the device drives serial data
    logic bit_clk;          // Resolved bit clock wire
    logic sdata_in;         // Resolved serial data wire
    // Undriven bit clock falls back to the other master
    assign bit_clk = bit_clk_dev_oe_n ? bit_clk_ext : bit_clk_dev;
    // Undriven serial data reads as a pulled-down line
    assign sdata_in = sdata_in_oe_n ? 1'b0 : sdata_in_dev;
    modport dev (
        input link_reset_n, sync, sdata_out, bit_clk,
        output bit_clk_dev, bit_clk_dev_oe_n, sdata_in_dev, sdata_in_oe_n
    );
    modport ctl (
        output link_reset_n, sync, sdata_out,
        input bit_clk, sdata_in
    );
endinterface

// ---- common/tal_pkg.sv ----
package tal_pkg;
    // One link slot word
    typedef logic [19:0] tal_word_t;
    // Which playback slot pair feeds the converters
    typedef enum logic [1:0] {
        TAL_ROUTE_FRONT,
        TAL_ROUTE_SURR,
        TAL_ROUTE_CLFE
    } tal_route_t;
endpackage

// ---- core/tal_ctl_port.sv ----
`timescale 1ns/1ps
`include "tal_cfg.svh"
module tal_ctl_port (
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    tal_link_if.ctl LINK,
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT
);
    import tal_pkg::*;

    logic run;              // Link out of reset
    logic rise;
    logic fall;
    logic [7:0] rx_pos;     // Position of bit now on the reply line
    logic [15:0] tag;       // Outgoing tag word
    tal_word_t right_eff;   // Right sample after mono copy
    tal_word_t tx_word;     // Word of the slot being sent
    logic [31:0] rd_val;
    logic [3:0] ctrl_reg, ctrl_next;
    tal_word_t left_reg, left_next;
    tal_word_t right_reg, right_next;
    logic [12:3] mask_reg, mask_next;
    logic pend_reg, pend_next;
    logic [6:0] pidx_reg, pidx_next;
    logic cur_reg, cur_next;
    logic [6:0] cidx_reg, cidx_next;
    logic sval_reg, sval_next;
    logic [6:0] sidx_reg, sidx_next;
    logic [15:0] sdat_reg, sdat_next;
    logic rdy_reg, rdy_next;
    logic [2:0] rtag_reg, rtag_next;
    logic [39:0] rsh_reg, rsh_next;
    logic [31:0] rdata_reg, rdata_next;
    logic prev_reg, prev_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [3:0] slot_reg, slot_next;
    logic [4:0] bit_reg, bit_next;
    logic sync_reg, sync_next;
    logic sdo_reg, sdo_next;

    // Next state of registers, frame generator and reply capture
    always_comb begin
        run = ctrl_reg[`TAL_CTRL_RUN];
        rise = LINK.bit_clk && !prev_reg;
        fall = !LINK.bit_clk && prev_reg;
        rx_pos = cnt_reg - 8'h02;
        right_eff = ctrl_reg[`TAL_CTRL_MONO] ? left_reg : right_reg;
        tag = 16'h0000;
        tag[14] = cur_reg;
        for (int n = 3; n <= 12; n++) begin
            tag[15 - n] = mask_reg[n];
        end
        tag[15] = |tag[14:0];
        if (slot_reg == 4'h0) begin
            tx_word = {4'h0, tag};
        end else if (slot_reg == 4'h1) begin
            tx_word = cur_reg ? {1'b1, cidx_reg, 12'h000} : 20'h00000;
        end else if (slot_reg > 4'h2 && slot_reg <= `TAL_LAST_SLOT
            && mask_reg[slot_reg]) begin
            // Left-type and right-type slots; samples are MSB first
            unique case (slot_reg)
                `TAL_SLOT_FRONT_L, `TAL_SLOT_CLFE_L, `TAL_SLOT_SURR_L:
                    tx_word = left_reg;
                `TAL_SLOT_FRONT_R, `TAL_SLOT_CLFE_R, `TAL_SLOT_SURR_R:
                    tx_word = right_eff;
                default: tx_word = 20'h00000;
            endcase
        end else begin
            tx_word = 20'h00000;
        end
        unique case (ADDR_IN)
            `TAL_REG_CTRL: rd_val = {28'h0000000, ctrl_reg};
            `TAL_REG_LEFT: rd_val = {12'h000, left_reg};
            `TAL_REG_RIGHT: rd_val = {12'h000, right_reg};
            `TAL_REG_MASK: rd_val = {19'h00000, mask_reg, 3'h0};
            `TAL_REG_CMD: rd_val = {24'h000000, pend_reg, pidx_reg};
            `TAL_REG_STAT: rd_val = {sval_reg, rdy_reg, 7'h00, sidx_reg,
                sdat_reg};
            default: rd_val = 32'h00000000;
        endcase
        ctrl_next = ctrl_reg;
        left_next = left_reg;
        right_next = right_reg;
        mask_next = mask_reg;
        pend_next = pend_reg;
        pidx_next = pidx_reg;
        cur_next = cur_reg;
        cidx_next = cidx_reg;
        sval_next = sval_reg;
        sidx_next = sidx_reg;
        sdat_next = sdat_reg;
        rdy_next = rdy_reg;
        rtag_next = rtag_reg;
        rsh_next = rsh_reg;
        rdata_next = RD_IN ? rd_val : 32'h00000000;
        prev_next = LINK.bit_clk;
        cnt_next = cnt_reg;
        slot_next = slot_reg;
        bit_next = bit_reg;
        sync_next = sync_reg;
        sdo_next = sdo_reg;
        // Reading status clears the reply flag
        if (RD_IN && ADDR_IN == `TAL_REG_STAT) begin
            sval_next = 1'b0;
        end
        if (!run) begin
            // Straps sit on the link while it is held in reset
            sync_next = ctrl_reg[`TAL_CTRL_VEND];
            sdo_next = ctrl_reg[`TAL_CTRL_ATE];
            cnt_next = 8'h00;
            slot_next = `TAL_LAST_SLOT;
            bit_next = 5'h00;
            cur_next = 1'b0;
            rdy_next = 1'b0;
        end else if (rise) begin
            // Data and sync change on the rising edge
            sync_next = cnt_reg < `TAL_SYNC_BITS;
            sdo_next = tx_word[bit_reg];
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'h00) begin
                slot_next = 4'h0;
                bit_next = `TAL_TAG_TOP;
                cur_next = pend_reg;
                cidx_next = pidx_reg;
                pend_next = 1'b0;
            end else if (bit_reg == 5'h00) begin
                slot_next = slot_reg + 4'h1;
                bit_next = `TAL_SLOT_TOP;
            end else begin
                bit_next = bit_reg - 5'h01;
            end
        end else if (fall) begin
            // Reply bits are sampled on the falling edge
            rsh_next = {rsh_reg[38:0], LINK.sdata_in};
            if (rx_pos == 8'h00) begin
                rdy_next = LINK.sdata_in;
            end
            if (rx_pos == 8'h01 || rx_pos == 8'h02) begin
                rtag_next = {rtag_reg[1:0], LINK.sdata_in};
            end
            if (rx_pos == `TAL_RX_S2_END && rtag_reg[1:0] == 2'h3) begin
                sval_next = 1'b1;
                sidx_next = rsh_reg[37:31];
                sdat_next = rsh_next[19:4];
            end
        end
        // A new command is never lost to the frame-start handover
        if (WR_IN) begin
            unique case (ADDR_IN)
                `TAL_REG_CTRL: ctrl_next = WDATA_IN[3:0];
                `TAL_REG_LEFT: left_next = WDATA_IN[19:0];
                `TAL_REG_RIGHT: right_next = WDATA_IN[19:0];
                `TAL_REG_MASK: mask_next = WDATA_IN[12:3];
                `TAL_REG_CMD: begin
                    pend_next = 1'b1;
                    pidx_next = WDATA_IN[6:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Register all state
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ctrl_reg <= `TAL_CTRL_RST;
            left_reg <= 20'h00000;
            right_reg <= 20'h00000;
            mask_reg <= 10'h000;
            pend_reg <= 1'b0;
            pidx_reg <= 7'h00;
            cur_reg <= 1'b0;
            cidx_reg <= 7'h00;
            sval_reg <= 1'b0;
            sidx_reg <= 7'h00;
            sdat_reg <= 16'h0000;
            rdy_reg <= 1'b0;
            rtag_reg <= 3'h0;
            rsh_reg <= 40'h0000000000;
            rdata_reg <= 32'h00000000;
            prev_reg <= 1'b0;
            cnt_reg <= 8'h00;
            slot_reg <= 4'h0;
            bit_reg <= 5'h00;
            sync_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            left_reg <= left_next;
            right_reg <= right_next;
            mask_reg <= mask_next;
            pend_reg <= pend_next;
            pidx_reg <= pidx_next;
            cur_reg <= cur_next;
            cidx_reg <= cidx_next;
            sval_reg <= sval_next;
            sidx_reg <= sidx_next;
            sdat_reg <= sdat_next;
            rdy_reg <= rdy_next;
            rtag_reg <= rtag_next;
            rsh_reg <= rsh_next;
            rdata_reg <= rdata_next;
            prev_reg <= prev_next;
            cnt_reg <= cnt_next;
            slot_reg <= slot_next;
            bit_reg <= bit_next;
            sync_reg <= sync_next;
            sdo_reg <= sdo_next;
        end
    end

    assign LINK.link_reset_n = run;
    assign LINK.sync = sync_reg;
    assign LINK.sdata_out = sdo_reg;
    assign RDATA_OUT = rdata_reg;
endmodule

// ---- core/tal_dev_port.sv ----
`timescale 1ns/1ps
`include "tal_cfg.svh"
// Summary of operation
// - Data high at release: outputs float
// - Sync high at release: internal test flag
// - Test mode held until clean reset
// - Controller holds inputs low at release; here it drives the ATE and VEND control bits onto them
// - Other indices read back as zero
// - Playback in; only identification read back
// - Twelve twenty-bit slots after tag
// - Select low: master drives bit clock
// - Exactly one master per link
// - Fixed bit clock, sync divided down
// - Send on rising, sample on falling
// - Tag slot; invalid slots ignored
// - Sync high sixteen bit clocks
// - Frame valid bit, twelve slot flags
// - Sync seen falling, data next rising
// - Controller converts to fixed rate
// - Slots MSB first, zero filled
// - Mono duplicated into both slots
// - Slot one: direction and index
// - Index selects even sixteen-bit words
// - Select picks playback slot pair
// - Tag bit fifteen shows ready
// - Reply slot one echoes index
// - Reply slot two carries data
module tal_dev_port #(
    parameter logic [15:0] VENDOR_ID1 = 16'hA5A5, // Arbitrary value
    parameter logic [15:0] VENDOR_ID2 = 16'h5A5A  // Arbitrary value
) (
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    tal_link_if.dev LINK,
    input wire logic SLOT_SEL_IN,
    input wire logic SLOT_SEL_FLOAT_IN,
    output tal_pkg::tal_word_t DAC_LEFT_OUT,
    output tal_pkg::tal_word_t DAC_RIGHT_OUT,
    output logic DAC_STROBE_OUT,
    output logic DAC_READY_OUT,
    output logic TEST_ATE_OUT,
    output logic TEST_VENDOR_OUT
);
    import tal_pkg::*;

    localparam logic [3:0] HALF_M1 = 4'(`TAL_BCLK_HALF_CYC - 1);

    logic master;            // Device owns the bit clock
    logic bclk_seen;         // Bit clock the logic runs on
    logic rise;              // Rising bit clock edge this cycle
    logic fall;              // Falling bit clock edge this cycle
    logic slot_ok;           // Current slot tagged valid
    logic ate_on;            // Outputs floated
    tal_route_t route;       // Selected slot pair
    logic [3:0] left_slot;
    logic [3:0] right_slot;
    tal_word_t rx_word;      // Shift value including this bit
    tal_word_t tx_word;      // Word sent in current slot
    logic [15:0] resp_data;  // Read data for the echoed index
    // Registered state and next values
    logic [3:0] div_reg, div_next;
    logic bclk_reg, bclk_next;
    logic prev_reg, prev_next;
    logic sync_prev_reg, sync_prev_next;
    logic in_frame_reg, in_frame_next;
    logic [3:0] slot_reg, slot_next;
    logic [4:0] bit_reg, bit_next;
    tal_word_t shift_reg, shift_next;
    logic [15:0] tag_reg, tag_next;
    logic req_reg, req_next;
    logic [6:0] req_idx_reg, req_idx_next;
    logic resp_reg, resp_next;
    logic [6:0] resp_idx_reg, resp_idx_next;
    logic ready_reg, ready_next;
    logic ate_reg, ate_next;
    logic vend_reg, vend_next;
    tal_word_t lhold_reg, lhold_next;
    tal_word_t left_reg, left_next;
    tal_word_t right_reg, right_next;
    logic strobe_reg, strobe_next;
    logic sdin_reg, sdin_next;

    // Decode the select pin and the slot pair it picks
    always_comb begin
        if (SLOT_SEL_FLOAT_IN) begin
            route = TAL_ROUTE_CLFE;
        end else if (SLOT_SEL_IN) begin
            route = TAL_ROUTE_SURR;
        end else begin
            route = TAL_ROUTE_FRONT;
        end
        unique case (route)
            TAL_ROUTE_FRONT: begin
                left_slot = `TAL_SLOT_FRONT_L;
                right_slot = `TAL_SLOT_FRONT_R;
            end
            TAL_ROUTE_SURR: begin
                left_slot = `TAL_SLOT_SURR_L;
                right_slot = `TAL_SLOT_SURR_R;
            end
            TAL_ROUTE_CLFE: begin
                left_slot = `TAL_SLOT_CLFE_L;
                right_slot = `TAL_SLOT_CLFE_R;
            end
        endcase
    end

    // Next state of divider, framing, command and reply logic
    always_comb begin
        master = !SLOT_SEL_IN && !SLOT_SEL_FLOAT_IN;
        // Slave mode runs everything from the incoming clock
        bclk_seen = master ? bclk_reg : LINK.bit_clk;
        rise = bclk_seen && !prev_reg;
        fall = !bclk_seen && prev_reg;
        ate_on = ate_reg && LINK.link_reset_n;
        rx_word = {shift_reg[18:0], LINK.sdata_out};
        slot_ok = tag_reg[15] && tag_reg[4'hF - slot_reg];
        // Only the two identification words answer
        if (resp_idx_reg == `TAL_IDX_VID1) begin
            resp_data = VENDOR_ID1;
        end else if (resp_idx_reg == `TAL_IDX_VID2) begin
            resp_data = VENDOR_ID2;
        end else begin
            resp_data = 16'h0000;
        end
        unique case (slot_reg)
            4'h0: tx_word = {4'h0, ready_reg, resp_reg, resp_reg,
                13'h0000};
            4'h1: tx_word = resp_reg ? {1'b0, resp_idx_reg, 12'h000}
                : 20'h00000;
            4'h2: tx_word = resp_reg ? {resp_data, 4'h0}
                : 20'h00000;
            default: tx_word = 20'h00000;
        endcase
        div_next = div_reg;
        bclk_next = bclk_reg;
        prev_next = bclk_seen;
        sync_prev_next = sync_prev_reg;
        in_frame_next = in_frame_reg;
        slot_next = slot_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        tag_next = tag_reg;
        req_next = req_reg;
        req_idx_next = req_idx_reg;
        resp_next = resp_reg;
        resp_idx_next = resp_idx_reg;
        ready_next = ready_reg;
        ate_next = ate_reg;
        vend_next = vend_reg;
        lhold_next = lhold_reg;
        left_next = left_reg;
        right_next = right_reg;
        strobe_next = 1'b0;
        sdin_next = sdin_reg;
        // Master clock divider, held low in reset or as slave
        if (!LINK.link_reset_n || !master) begin
            div_next = 4'h0;
            bclk_next = 1'b0;
        end else if (div_reg == HALF_M1) begin
            div_next = 4'h0;
            bclk_next = !bclk_reg;
        end else begin
            div_next = div_reg + 4'h1;
        end
        if (!LINK.link_reset_n) begin
            // Straps are tracked so the last value before release sticks
            ate_next = LINK.sdata_out;
            vend_next = LINK.sync;
            sync_prev_next = 1'b0;
            in_frame_next = 1'b0;
            slot_next = `TAL_LAST_SLOT;
            bit_next = 5'h00;
            tag_next = 16'h0000;
            req_next = 1'b0;
            resp_next = 1'b0;
            ready_next = 1'b0;
            sdin_next = 1'b0;
        end else if (rise) begin
            // Serial data changes only on rising edges
            sdin_next = in_frame_reg && tx_word[bit_reg];
        end else if (fall) begin
            sync_prev_next = LINK.sync;
            if (in_frame_reg) begin
                // Sample on the falling edge
                shift_next = rx_word;
                if (bit_reg != 5'h00) begin
                    bit_next = bit_reg - 5'h01;
                end else begin
                    bit_next = `TAL_SLOT_TOP;
                    slot_next = slot_reg + 4'h1;
                    if (slot_reg == `TAL_LAST_SLOT) begin
                        in_frame_next = 1'b0;
                    end
                    if (slot_reg == 4'h0) begin
                        tag_next = rx_word[15:0];
                    end else if (slot_ok) begin
                        // Invalid slots fall through untouched
                        if (slot_reg == 4'h1 && rx_word[19]) begin
                            req_next = 1'b1;
                            req_idx_next = rx_word[18:12];
                        end
                        if (slot_reg == left_slot) begin
                            lhold_next = rx_word;
                        end
                        if (slot_reg == right_slot) begin
                            left_next = lhold_reg;
                            right_next = rx_word;
                            strobe_next = 1'b1;
                        end
                    end
                end
            end
            // Sync rise overrides the tail of the previous frame
            if (LINK.sync && !sync_prev_reg) begin
                in_frame_next = 1'b1;
                slot_next = 4'h0;
                bit_next = `TAL_TAG_TOP;
                resp_next = req_reg;
                resp_idx_next = req_idx_reg;
                req_next = 1'b0;
                ready_next = 1'b1;
            end
        end
    end

    // Register all state
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            div_reg <= 4'h0;
            bclk_reg <= 1'b0;
            prev_reg <= 1'b0;
            sync_prev_reg <= 1'b0;
            in_frame_reg <= 1'b0;
            slot_reg <= 4'h0;
            bit_reg <= 5'h00;
            shift_reg <= 20'h00000;
            tag_reg <= 16'h0000;
            req_reg <= 1'b0;
            req_idx_reg <= 7'h00;
            resp_reg <= 1'b0;
            resp_idx_reg <= 7'h00;
            ready_reg <= 1'b0;
            ate_reg <= 1'b0;
            vend_reg <= 1'b0;
            lhold_reg <= 20'h00000;
            left_reg <= 20'h00000;
            right_reg <= 20'h00000;
            strobe_reg <= 1'b0;
            sdin_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            bclk_reg <= bclk_next;
            prev_reg <= prev_next;
            sync_prev_reg <= sync_prev_next;
            in_frame_reg <= in_frame_next;
            slot_reg <= slot_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            tag_reg <= tag_next;
            req_reg <= req_next;
            req_idx_reg <= req_idx_next;
            resp_reg <= resp_next;
            resp_idx_reg <= resp_idx_next;
            ready_reg <= ready_next;
            ate_reg <= ate_next;
            vend_reg <= vend_next;
            lhold_reg <= lhold_next;
            left_reg <= left_next;
            right_reg <= right_next;
            strobe_reg <= strobe_next;
            sdin_reg <= sdin_next;
        end
    end

    // Pin drivers; board test floats both link outputs
    assign LINK.bit_clk_dev = bclk_reg;
    assign LINK.bit_clk_dev_oe_n = !master || ate_on;
    assign LINK.sdata_in_dev = sdin_reg;
    assign LINK.sdata_in_oe_n = ate_on;
    assign DAC_LEFT_OUT = left_reg;
    assign DAC_RIGHT_OUT = right_reg;
    assign DAC_STROBE_OUT = strobe_reg;
    assign DAC_READY_OUT = ready_reg;
    assign TEST_ATE_OUT = ate_on;
    // Internal test leaves pin levels as they are
    assign TEST_VENDOR_OUT = vend_reg && LINK.link_reset_n;
endmodule

// ---- dv/tal_link_asserts.sv ----
`timescale 1ns/1ps
module tal_link_asserts (
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    input wire logic link_reset_n,
    input wire logic sync,
    input wire logic sdata_out,
    input wire logic bit_clk,
    input wire logic bit_clk_dev,
    input wire logic bit_clk_dev_oe_n,
    input wire logic sdata_in_oe_n
);
    logic [4:0] hi_reg; // Bit clock rises in tag phase, 1F = not yet framed
    logic [4:0] hi_next;
    logic prev_reg; // Bit clock one cycle back
    logic prev_next;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Marker 1F skips the strapped sync that precedes the first frame
    always_comb begin
        prev_next = bit_clk;
        hi_next = hi_reg;
        if (!link_reset_n) begin
            hi_next = 5'h1F;
        end else if (!sync) begin
            hi_next = 5'h00;
        end else if (hi_reg != 5'h1F && bit_clk && !prev_reg) begin
            hi_next = hi_reg + 5'h01;
        end
    end
    // Registers only
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            hi_reg <= 5'h1F;
            prev_reg <= 1'b0;
        end else begin
            hi_reg <= hi_next;
            prev_reg <= prev_next;
        end
    end
    a_ate_both_float: assert property (
        sdata_in_oe_n |-> bit_clk_dev_oe_n)
        else $error("bit clock still driven in board test");
    a_ate_strap_entry: assert property (
        $rose(link_reset_n) && $past(sdata_out) |-> ##[0:2] sdata_in_oe_n)
        else $error("board test not entered");
    a_test_mode_held: assert property (
        link_reset_n && $past(sdata_in_oe_n) |-> sdata_in_oe_n)
        else $error("board test left without reset");
    a_clean_exit: assert property (
        $rose(link_reset_n) && !$past(sdata_out) |-> !sdata_in_oe_n [*3])
        else $error("data output floated after clean reset");
    a_clk_parked: assert property (
        !link_reset_n && !$past(link_reset_n) |-> !bit_clk_dev)
        else $error("bit clock runs during link reset");
    // Divider restarts one cycle after release, so two clean cycles first
    a_master_toggle: assert property (
        !bit_clk_dev_oe_n && link_reset_n && $past(link_reset_n)
        && $past(link_reset_n, 2) |-> bit_clk_dev != $past(bit_clk_dev))
        else $error("master bit clock stalled");
    a_send_rising: assert property (
        link_reset_n && $past(link_reset_n) && $changed({sync, sdata_out})
        |-> $past(bit_clk) && !$past(bit_clk, 2))
        else $error("link output moved off a rising bit clock");
    a_tag_length: assert property (
        $fell(sync) && link_reset_n && hi_reg != 5'h1F |-> hi_reg == 5'h10)
        else $error("sync high length wrong");
endmodule

// ---- dv/tdm_audio_link_dac_port_tb_top.sv ----
`timescale 1ns/1ps
module tdm_audio_link_dac_port_tb_top;
    import tal_pkg::*;
    localparam logic [15:0] ID1 = 16'h1357; // Arbitrary value
    localparam logic [15:0] ID2 = 16'h2468; // Arbitrary value
    logic clk, rst, wr, rd, stb, rdy, t_ate, t_ven, sel, bx;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    tal_word_t dac_l, dac_r;
    logic [6:0] idx [3] = '{7'h7C, 7'h7E, 7'h02};
    logic [15:0] val [3] = '{ID1, ID2, 16'h0000};
    int bad_count, n_checks, cyc;
    tal_link_if link_if ();
    // Stand-in master bit clock, running only while the device is slave
    always @(posedge clk) bx <= sel && !bx;
    assign link_if.bit_clk_ext = bx;
    tal_dev_port #(.VENDOR_ID1(ID1), .VENDOR_ID2(ID2)) tal_dev_port_inst (
        .CLOCK_IN(clk), .SYS_RST_IN(rst), .LINK(link_if),
        .SLOT_SEL_IN(sel), .SLOT_SEL_FLOAT_IN(1'b0), .DAC_LEFT_OUT(dac_l),
        .DAC_RIGHT_OUT(dac_r), .DAC_STROBE_OUT(stb), .DAC_READY_OUT(rdy),
        .TEST_ATE_OUT(t_ate), .TEST_VENDOR_OUT(t_ven));
    tal_ctl_port tal_ctl_port_inst (.CLOCK_IN(clk), .SYS_RST_IN(rst),
        .LINK(link_if), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata));
    tal_link_asserts tal_link_asserts_inst (.CLOCK_IN(clk), .SYS_RST_IN(rst),
        .link_reset_n(link_if.link_reset_n), .sync(link_if.sync),
        .sdata_out(link_if.sdata_out), .bit_clk(link_if.bit_clk),
        .bit_clk_dev(link_if.bit_clk_dev),
        .bit_clk_dev_oe_n(link_if.bit_clk_dev_oe_n),
        .sdata_in_oe_n(link_if.sdata_in_oe_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Gap edge before each strobe keeps drivers single per step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, nearly three times the seven thousand or so cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("MISMATCH t=%0t timeout", $time);
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        sel = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h20, 32'h0); // Unmapped place reads zero
        wr_reg(8'h00, 32'h1);
        wr_reg(8'h04, 32'h12345);
        wr_reg(8'h08, 32'h6789A);
        wr_reg(8'h0C, 32'h18);
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h10, {25'h0, idx[i]});
            repeat (2000) @(posedge clk);
            rd_reg(8'h14, {9'h180, idx[i], val[i]});
        end
        chk({11'h0, rdy, dac_l}, 32'h112345);
        chk({12'h0, dac_r}, 32'h6789A);
        wr_reg(8'h00, 32'h2);
        wr_reg(8'h00, 32'h3);
        repeat (4) @(posedge clk);
        chk({29'h0, t_ate, link_if.sdata_in_oe_n,
            link_if.bit_clk_dev_oe_n}, 32'h7);
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h00, 32'h1);
        repeat (4) @(posedge clk);
        chk({30'h0, t_ate, link_if.sdata_in_oe_n}, 32'h0);
        wr_reg(8'h00, 32'h4);
        wr_reg(8'h00, 32'h5);
        repeat (4) @(posedge clk);
        chk({30'h0, t_ven, link_if.bit_clk_dev_oe_n}, 32'h2);
        // Slave on slots 7 and 8 only; mono copies left into right
        sel <= 1'b1;
        wr_reg(8'h0C, 32'h180);
        wr_reg(8'h04, 32'h0ABCD);
        wr_reg(8'h00, 32'h9);
        // The first pair may straddle the writes, the second cannot
        repeat (2) @(posedge clk iff stb);
        #1 chk({12'h0, dac_l}, 32'h0ABCD);
        chk({12'h0, dac_r}, 32'h0ABCD);
        complete_run();
    end
endmodule
